// ---- tsq_sequencer.sv ----
// Operation
// - Sync word length selectable from one to four bytes by two-bit field
// - Sync order: byte 3, then 2, 1, 0 as length allows
// - Transmit-on without FIFO reload resends last packet
// - Replay only for packets held wholly in the FIFO
// - Auto-transmit option starts sending based on FIFO fill
// - Auto-transmit enters transmit once fill exceeds almost-full threshold and no interrupt status bit is set
// - Auto-transmit frames packets with configured packet length
// - Software reset holds internal reset for 50 to 470 us
// - Shutdown exit and power-up hold reset 5 to 40 ms
// - Any reset returns all registers to defaults
// - Reset driven on gpio0, inverted reset on gpio1
`include "tsq_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module tsq_sequencer #(
  parameter int DEPTH = 64,
  parameter int AW = 6,
  parameter int SW_CYCLES = `TSQ_SWRST_CYCLES,
  parameter int GLITCH_CYCLES = `TSQ_GLITCH_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic shutdown_pin,
  output logic tx_bit,
  output logic tx_bit_valid,
  output logic tx_active,
  output logic gpio0,
  output logic gpio1,
  output logic irq
);
  logic [2:0] shdn_sync_reg;
  logic shdn_reg;
  logic shut_rise;
  logic rst_active;
  logic sw_req;
  logic srst;
  logic [7:0] ctrl_reg;
  logic [31:0] sync_reg;
  logic [7:0] pktlen_reg;
  logic [7:0] thresh_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic [7:0] mem_reg [DEPTH];
  logic [AW:0] wcnt_reg;
  logic [AW:0] rptr_reg;
  logic reloaded_reg;
  logic overflow_reg;
  tsq_pkg::tsq_state_e state_reg;
  logic [1:0] sidx_reg;
  logic [7:0] dcnt_reg;
  logic acc;
  logic wr;
  logic rd;
  logic fifo_wr;
  logic start;
  logic done_pulse;
  logic aempty_set;
  logic [AW:0] remain;
  tsq_byte_if bif ();

  // Shutdown pin: three stages, change taken when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shdn_sync_reg <= 3'b000;
      shdn_reg <= 1'b0;
    end else begin
      shdn_sync_reg <= {shdn_sync_reg[1:0], shutdown_pin};
      if (shdn_sync_reg[1] == shdn_sync_reg[2]) begin
        shdn_reg <= shdn_sync_reg[2];
      end
    end
  end
  // One-cycle pulse as the filtered pin leaves shutdown
  assign shut_rise = shdn_reg && shdn_sync_reg[1] == shdn_sync_reg[2] && !shdn_sync_reg[2];

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign sw_req = wr && paddr == `TSQ_OFF_CTRL && pwdata[`TSQ_CTRL_SWRST];
  assign srst = rst_active;

  tsq_reset_gen #(.SW_CYCLES(SW_CYCLES), .GLITCH_CYCLES(GLITCH_CYCLES)) u_rst (
    .pclk(pclk),
    .presetn(presetn),
    .sw_req(sw_req),
    .shut_rise(shut_rise),
    .rst_active(rst_active)
  );

  tsq_serializer u_ser (
    .pclk(pclk),
    .presetn(presetn),
    .bif(bif)
  );

  // Configuration registers, returned to defaults while internal reset holds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 8'h00;
      sync_reg <= `TSQ_SYNC_RST;
      pktlen_reg <= `TSQ_PKTLEN_RST;
      thresh_reg <= `TSQ_THRESH_RST;
      irq_mask_reg <= 2'b00;
    end else if (srst) begin
      ctrl_reg <= 8'h00;
      sync_reg <= `TSQ_SYNC_RST;
      pktlen_reg <= `TSQ_PKTLEN_RST;
      thresh_reg <= `TSQ_THRESH_RST;
      irq_mask_reg <= 2'b00;
    end else begin
      if (done_pulse) begin
        ctrl_reg[`TSQ_CTRL_TXON] <= 1'b0;
      end
      if (wr) begin
        case (paddr)
          `TSQ_OFF_CTRL: ctrl_reg <= {pwdata[7:3], 1'b0, pwdata[1:0]};
          `TSQ_OFF_SYNC: sync_reg <= pwdata;
          `TSQ_OFF_PKTLEN: pktlen_reg <= pwdata[7:0];
          `TSQ_OFF_THRESH: thresh_reg <= pwdata[7:0];
          `TSQ_OFF_IRQ_MASK: irq_mask_reg <= pwdata[1:0];
          default: ;
        endcase
      end
    end
  end

  assign fifo_wr = wr && paddr == `TSQ_OFF_FIFO && state_reg == tsq_pkg::TSQ_IDLE;

  // FIFO write side; a load after a finished packet starts a new packet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcnt_reg <= '0;
      reloaded_reg <= 1'b0;
      overflow_reg <= 1'b0;
    end else if (srst) begin
      wcnt_reg <= '0;
      reloaded_reg <= 1'b0;
      overflow_reg <= 1'b0;
    end else if (fifo_wr) begin
      if (!reloaded_reg) begin
        wcnt_reg <= (AW+1)'(1);
        overflow_reg <= 1'b0;
      end else if (wcnt_reg == (AW+1)'(DEPTH)) begin
        overflow_reg <= 1'b1;
      end else begin
        wcnt_reg <= wcnt_reg + (AW+1)'(1);
      end
      reloaded_reg <= 1'b1;
    end else if (done_pulse) begin
      reloaded_reg <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_mem
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem_reg[gi] <= 8'h00;
        end else if (fifo_wr && (reloaded_reg ? wcnt_reg == (AW+1)'(gi) : gi == 0)) begin
          mem_reg[gi] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // Start: txon replays held packet; autotx when fill passes threshold with no interrupt status pending
  assign start = state_reg == tsq_pkg::TSQ_IDLE && !srst && wcnt_reg != '0 && !overflow_reg
    && ((ctrl_reg[`TSQ_CTRL_TXON])
    || (ctrl_reg[`TSQ_CTRL_AUTOTX] && irq_stat_reg == 2'b00
        && 8'(wcnt_reg) > thresh_reg));

  assign bif.load = !bif.busy && (state_reg == tsq_pkg::TSQ_SYNC
    || (state_reg == tsq_pkg::TSQ_DATA && dcnt_reg != 8'h00));
  assign bif.data = state_reg == tsq_pkg::TSQ_SYNC ? sync_reg[{sidx_reg, 3'b000} +: 8]
    : mem_reg[rptr_reg[AW-1:0]];
  assign done_pulse = state_reg == tsq_pkg::TSQ_DONE;
  assign remain = wcnt_reg - rptr_reg;
  assign aempty_set = state_reg == tsq_pkg::TSQ_DATA && bif.load
    && remain == (AW+1)'(`TSQ_AEMPTY_LVL);

  // Frame sequencer: sync bytes 3 down to 3-len, then packet bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= tsq_pkg::TSQ_IDLE;
      sidx_reg <= 2'd3;
      dcnt_reg <= 8'h00;
      rptr_reg <= '0;
    end else if (srst) begin
      state_reg <= tsq_pkg::TSQ_IDLE;
      sidx_reg <= 2'd3;
      dcnt_reg <= 8'h00;
      rptr_reg <= '0;
    end else begin
      case (state_reg)
        tsq_pkg::TSQ_IDLE: begin
          if (start) begin
            state_reg <= tsq_pkg::TSQ_SYNC;
            sidx_reg <= 2'd3;
            rptr_reg <= '0;
            // Packet length from the configured setting, capped by held bytes
            dcnt_reg <= (pktlen_reg < 8'(wcnt_reg)) ? pktlen_reg : 8'(wcnt_reg);
          end
        end
        tsq_pkg::TSQ_SYNC: begin
          if (bif.load) begin
            if (sidx_reg == 2'd3 - ctrl_reg[`TSQ_CTRL_SYNCLEN_HI:`TSQ_CTRL_SYNCLEN_LO]) begin
              state_reg <= tsq_pkg::TSQ_DATA;
            end else begin
              sidx_reg <= sidx_reg - 2'd1;
            end
          end
        end
        tsq_pkg::TSQ_DATA: begin
          if (bif.load) begin
            dcnt_reg <= dcnt_reg - 8'h01;
            rptr_reg <= rptr_reg + (AW+1)'(1);
          end else if (dcnt_reg == 8'h00 && !bif.busy) begin
            state_reg <= tsq_pkg::TSQ_DONE;
          end
        end
        tsq_pkg::TSQ_DONE: state_reg <= tsq_pkg::TSQ_IDLE;
        default: state_reg <= tsq_pkg::TSQ_IDLE;
      endcase
    end
  end

  // Sticky interrupts: set wins over write-one clear and over read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= 2'b00;
    end else if (srst) begin
      irq_stat_reg <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == `TSQ_IRQ_PKSENT && done_pulse) || (i == `TSQ_IRQ_ALMOST_EMPTY && aempty_set)) begin
          irq_stat_reg[i] <= 1'b1;
        end else if ((wr && paddr == `TSQ_OFF_IRQ_STAT && pwdata[i])
            || (rd && paddr == `TSQ_OFF_IRQ_STAT)) begin
          irq_stat_reg[i] <= 1'b0;
        end
      end
    end
  end

  // APB read data and registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          `TSQ_OFF_CTRL: prdata <= {24'h00_0000, ctrl_reg};
          `TSQ_OFF_SYNC: prdata <= sync_reg;
          `TSQ_OFF_PKTLEN: prdata <= {24'h00_0000, pktlen_reg};
          `TSQ_OFF_THRESH: prdata <= {24'h00_0000, thresh_reg};
          `TSQ_OFF_STATUS: prdata <= {16'h0000, 3'b000, overflow_reg, 4'(state_reg),
            8'(wcnt_reg)};
          `TSQ_OFF_IRQ_STAT: prdata <= {30'h0000_0000, irq_stat_reg};
          `TSQ_OFF_IRQ_MASK: prdata <= {30'h0000_0000, irq_mask_reg};
          `TSQ_OFF_FIFO: ;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_bit <= 1'b0;
      tx_bit_valid <= 1'b0;
      tx_active <= 1'b0;
      gpio0 <= 1'b1;
      gpio1 <= 1'b0;
      irq <= 1'b0;
    end else begin
      tx_bit <= bif.bit_out;
      tx_bit_valid <= bif.bit_valid;
      tx_active <= state_reg != tsq_pkg::TSQ_IDLE;
      gpio0 <= rst_active;
      gpio1 <= !rst_active;
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  a_sync_first_byte: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == tsq_pkg::TSQ_IDLE && start) |=> sidx_reg == 2'd3)
    else $error("sync does not start at byte 3");
  a_swrst_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    sw_req |=> rst_active [*8])
    else $error("software reset pulse too short");
  a_reset_pins: assert property (@(posedge pclk) disable iff (!presetn)
    gpio0 == $past(rst_active) && gpio1 == !$past(rst_active))
    else $error("gpio reset pins do not follow internal reset");
  a_no_overflow_tx: assert property (@(posedge pclk) disable iff (!presetn)
    overflow_reg |-> state_reg == tsq_pkg::TSQ_IDLE && !tx_active)
    else $error("oversized packet replayed");
  a_autotx_start: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == tsq_pkg::TSQ_IDLE && start) |=> state_reg == tsq_pkg::TSQ_SYNC)
    else $error("start did not enter sync");
  a_reset_defaults: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(rst_active) |-> ctrl_reg == 8'h00 && pktlen_reg == `TSQ_PKTLEN_RST)
    else $error("registers not at defaults after reset");
  a_pkt_len: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == tsq_pkg::TSQ_IDLE && start) |=> dcnt_reg <= pktlen_reg)
    else $error("packet longer than configured");
  a_replay_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    done_pulse |=> wcnt_reg == $past(wcnt_reg))
    else $error("held packet lost after send");
endmodule : tsq_sequencer
`default_nettype wire

// ---- tsq_regs.svh ----
`ifndef TSQ_REGS_SVH
`define TSQ_REGS_SVH

// Register byte offsets (APB, one word each)
`define TSQ_OFF_CTRL 12'h000
`define TSQ_OFF_SYNC 12'h004
`define TSQ_OFF_PKTLEN 12'h008
`define TSQ_OFF_THRESH 12'h00C
`define TSQ_OFF_STATUS 12'h010
`define TSQ_OFF_IRQ_STAT 12'h014
`define TSQ_OFF_IRQ_MASK 12'h018
`define TSQ_OFF_FIFO 12'h01C

// Control register fields
`define TSQ_CTRL_TXON 0
`define TSQ_CTRL_AUTOTX 1
`define TSQ_CTRL_SWRST 2
`define TSQ_CTRL_SYNCLEN_LO 4
`define TSQ_CTRL_SYNCLEN_HI 5

// Interrupt bits
`define TSQ_IRQ_PKSENT 0
`define TSQ_IRQ_ALMOST_EMPTY 1

// Reset values and almost-empty level
`define TSQ_SYNC_RST 32'h2DD4_0000
`define TSQ_PKTLEN_RST 8'h04
`define TSQ_THRESH_RST 8'h37
`define TSQ_AEMPTY_LVL 8'h04

// Timing: pulse lengths in microseconds and milliseconds, clock in MHz
`define TSQ_CLK_MHZ 100
`define TSQ_SWRST_MIN_US 50
`define TSQ_SWRST_MAX_US 470
`define TSQ_GLITCH_TYP_MS 15
`define TSQ_SWRST_CYCLES (`TSQ_SWRST_MIN_US * `TSQ_CLK_MHZ)
`define TSQ_GLITCH_CYCLES (`TSQ_GLITCH_TYP_MS * 1000 * `TSQ_CLK_MHZ)

`endif

// ---- tsq_pkg.sv ----
package tsq_pkg;
  typedef enum logic [3:0] {
    TSQ_IDLE = 4'b0001,
    TSQ_SYNC = 4'b0010,
    TSQ_DATA = 4'b0100,
    TSQ_DONE = 4'b1000
  } tsq_state_e;
  typedef logic [7:0] tsq_byte_t;
endpackage : tsq_pkg

// ---- tsq_byte_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface tsq_byte_if;
  logic load;
  tsq_pkg::tsq_byte_t data;
  logic busy;
  logic bit_out;
  logic bit_valid;
  modport src (output load, output data, input busy);
  modport ser (input load, input data, output busy, output bit_out, output bit_valid);
endinterface : tsq_byte_if
`default_nettype wire

// ---- tsq_serializer.sv ----
`timescale 1ns/1ns
`default_nettype none
module tsq_serializer (
  input wire logic pclk,
  input wire logic presetn,
  tsq_byte_if.ser bif
);
  logic [7:0] sh_reg;
  logic [3:0] cnt_reg;

  // Shift out MSB first, one bit per clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_reg <= 8'h00;
      cnt_reg <= 4'h0;
    end else if (bif.load && cnt_reg == 4'h0) begin
      sh_reg <= bif.data;
      cnt_reg <= 4'h8;
    end else if (cnt_reg != 4'h0) begin
      sh_reg <= {sh_reg[6:0], 1'b0};
      cnt_reg <= cnt_reg - 4'h1;
    end
  end

  assign bif.busy = (cnt_reg != 4'h0);
  assign bif.bit_out = sh_reg[7];
  assign bif.bit_valid = (cnt_reg != 4'h0);
endmodule : tsq_serializer
`default_nettype wire

// ---- tsq_reset_gen.sv ----
`timescale 1ns/1ns
`default_nettype none
module tsq_reset_gen #(
  parameter int SW_CYCLES = 5000,
  parameter int GLITCH_CYCLES = 1500000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sw_req,
  input wire logic shut_rise,
  output logic rst_active
);
  logic [23:0] cnt_reg;

  // Power-up and shutdown exit use the long pulse, software the short one
  // A software request never cuts a longer pulse that is still running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 24'(GLITCH_CYCLES);
    end else if (shut_rise) begin
      cnt_reg <= 24'(GLITCH_CYCLES);
    end else if (sw_req && cnt_reg < 24'(SW_CYCLES)) begin
      cnt_reg <= 24'(SW_CYCLES);
    end else if (cnt_reg != 24'h00_0000) begin
      cnt_reg <= cnt_reg - 24'h00_0001;
    end
  end

  assign rst_active = (cnt_reg != 24'h00_0000);
endmodule : tsq_reset_gen
`default_nettype wire

// ---- tsq_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module tsq_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // One transfer; the request holds until pready is seen high at an edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : tsq_host
`default_nettype wire

// ---- tx_sync_autotx_sequencer_tb.sv ----
`include "tsq_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module tx_sync_autotx_sequencer_tb;
  localparam int SW = 20;
  localparam int GLITCH = 200;
  localparam logic [31:0] SYNCW = 32'hA1B2_C3D4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, shutdown_pin;
  logic tx_bit, tx_bit_valid, tx_active, gpio0, gpio1, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic e;
  logic [63:0] cap = 64'h0;
  int ncap = 0;
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;

  tsq_sequencer #(.SW_CYCLES(SW), .GLITCH_CYCLES(GLITCH)) i_tsq_sequencer (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shutdown_pin(shutdown_pin), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
    .tx_active(tx_active), .gpio0(gpio0), .gpio1(gpio1), .irq(irq));
  tsq_host i_tsq_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (tx_bit_valid === 1'b1) begin
      cap <= {cap[62:0], tx_bit};
      ncap <= ncap + 1;
    end
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      mismatches++;
      results();
    end
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_tsq_host.xfer(1'b1, a, d, v, e);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    i_tsq_host.xfer(1'b0, a, 32'h0000_0000, v, e);
  endtask : rd

  // Measures how long gpio0 stays high once it rises
  task automatic pulse(input int lo, input int hi);
    int n;
    n = 0;
    while (gpio0 !== 1'b1 && n < 30) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (gpio0 === 1'b1 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    check(n >= lo && n <= hi, 1'b1);
  endtask : pulse

  // Waits for a packet to finish and compares the captured bit stream
  task automatic finish(input int code, input int nd, input logic [31:0] data);
    int n;
    logic [63:0] x;
    x = 64'h0;
    for (int i = 0; i <= code; i++) x = {x[55:0], SYNCW[8*(3-i)+:8]};
    for (int j = 0; j < nd; j++) x = {x[55:0], data[8*(nd-1-j)+:8]};
    n = 0;
    while (tx_active !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    while (tx_active === 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    repeat (3) @(posedge pclk);
    check(ncap, 8 * (code + 1 + nd));
    check(cap & ((64'h1 << (8 * (code + 1 + nd))) - 1), x);
  endtask : finish

  task automatic start();
    @(posedge pclk);
    ncap <= 0;
  endtask : start

  initial begin
    presetn = 1'b0;
    shutdown_pin = 1'b0;
    repeat (4) @(posedge pclk);
    check({gpio0, gpio1}, 2'b10);
    presetn <= 1'b1;
    pulse(GLITCH - 2, GLITCH + 4);
    check({gpio0, gpio1}, 2'b01);
    rd(`TSQ_OFF_SYNC);
    check(v, `TSQ_SYNC_RST);
    rd(`TSQ_OFF_PKTLEN);
    check(v[7:0], `TSQ_PKTLEN_RST);
    rd(`TSQ_OFF_THRESH);
    check(v[7:0], `TSQ_THRESH_RST);
    i_tsq_host.xfer(1'b0, 12'h020, 32'h0000_0000, v, e);
    check({e, v}, 33'h1_0000_0000);
    $display("test reset done");
    wr(`TSQ_OFF_SYNC, SYNCW);
    wr(`TSQ_OFF_PKTLEN, 32'h0000_0001);
    for (int c = 0; c < 4; c++) begin
      wr(`TSQ_OFF_FIFO, 32'h0000_005A);
      start();
      wr(`TSQ_OFF_CTRL, (c << 4) | 1);
      finish(c, 1, 32'h0000_005A);
    end
    start();
    wr(`TSQ_OFF_CTRL, 32'h0000_0031);
    finish(3, 1, 32'h0000_005A);
    $display("test sync and resend done");
    wr(`TSQ_OFF_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    check(irq, 1'b1);
    rd(`TSQ_OFF_IRQ_STAT);
    check(v[0], 1'b1);
    repeat (2) @(posedge pclk);
    check(irq, 1'b0);
    $display("test interrupt done");
    wr(`TSQ_OFF_THRESH, 32'h0000_0002);
    wr(`TSQ_OFF_PKTLEN, 32'h0000_0003);
    wr(`TSQ_OFF_CTRL, 32'h0000_0002);
    rd(`TSQ_OFF_IRQ_STAT);
    start();
    wr(`TSQ_OFF_FIFO, 32'h0000_0011);
    wr(`TSQ_OFF_FIFO, 32'h0000_0022);
    check(ncap, 0);
    wr(`TSQ_OFF_FIFO, 32'h0000_0033);
    finish(0, 3, 32'h0011_2233);
    wr(`TSQ_OFF_CTRL, 32'h0000_0000);
    rd(`TSQ_OFF_IRQ_STAT);
    $display("test autotx done");
    for (int k = 0; k < 65; k++) wr(`TSQ_OFF_FIFO, k);
    rd(`TSQ_OFF_STATUS);
    check(v[12], 1'b1);
    start();
    wr(`TSQ_OFF_CTRL, 32'h0000_0001);
    repeat (100) @(posedge pclk);
    check(ncap, 0);
    check(tx_active, 1'b0);
    $display("test overflow done");
    wr(`TSQ_OFF_THRESH, 32'h0000_0005);
    wr(`TSQ_OFF_CTRL, 32'h0000_0004);
    pulse(SW - 2, SW + 4);
    rd(`TSQ_OFF_THRESH);
    check(v[7:0], `TSQ_THRESH_RST);
    $display("test soft reset done");
    wr(`TSQ_OFF_SYNC, SYNCW);
    for (int k = 1; k < 6; k++) wr(`TSQ_OFF_FIFO, k);
    start();
    wr(`TSQ_OFF_CTRL, 32'h0000_0001);
    finish(0, 4, 32'h0102_0304);
    check(tx_active, 1'b0);
    rd(`TSQ_OFF_IRQ_STAT);
    check(v[1:0], 2'b11);
    $display("test packet length done");
    shutdown_pin <= 1'b1;
    repeat (10) @(posedge pclk);
    shutdown_pin <= 1'b0;
    pulse(GLITCH - 2, GLITCH + 4);
    check({gpio0, gpio1}, 2'b01);
    $display("test shutdown done");
    results();
  end
endmodule : tx_sync_autotx_sequencer_tb
`default_nettype wire
